/* dsa_consts.svh */
// constants for the dual data space access block
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH

// data word and address widths (word addresses)
`define DSA_DW         16
`define DSA_AW         8
`define DSA_BW         7
`define DSA_BRW        4

// fixed split of the combined range: x below, y from the base upward
`define DSA_X_WORDS    128
`define DSA_Y_WORDS    128
`define DSA_Y_BASE     8'h80

// reset and idle values
`define DSA_DATA_RST   16'h0000
`define DSA_ADDR_ONE   8'h01
`define DSA_IDX_RST    7'h00

`endif

/* dsa_core_model.sv */
// core-side model issuing operand reads and writes
`timescale 1ns/1ps
module dsa_core_model
  import dsa_pkg::*;
(
  input  wire logic ref_clk,
  output logic      rd_valid,
  output dsa_rd_s   rd_req,
  output dsa_wr_s   wr_req
);
  // idle until the first request
  initial begin
    rd_valid = 1'b0;
    rd_req = '0;
    wr_req = '0;
  end
  // a request changes just after an edge and holds a full cycle, never stalled
  task automatic drive(input logic v, input dsa_rd_s r, input dsa_wr_s w);
    @(posedge ref_clk);
    rd_valid <= v;
    rd_req   <= r;
    wr_req   <= w;
  endtask
endmodule

/* dsa_data_space.sv */
// dual x/y data space storage with two address generators and combined-range writes
//
// Behaviour
// - two spaces, x and y, each with its own address generator and data path.
// - the mac class sees x and y as separate spaces, all other reads and writes one range.
// - the x space serves every operation and every address generator mode.
// - x has a read data bus and a separate write data bus.
// - the x read bus returns combined-range reads and the x operand of the mac class.
// - y is read, next to x, only by the mac class of operations.
// - modulo addressing works on both spaces for every operation.
// - bit-reversed addressing applies only to writes whose plain address lies in x.
// - with the dsp engine absent, modulo and bit-reversed modes fall back to plain.
// - every write, dsp ones included, is decoded against the combined range.
// - the x/y boundary is a fixed constant with no software control.
`timescale 1ns/1ps

module dsa_data_space
  import dsa_pkg::*;
#(
  parameter bit DSP_ENGINE = 1'b1
) (
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire logic      rd_valid,
  input  dsa_rd_s        rd_req,
  input  dsa_wr_s        wr_req,
  output dsa_rsp_s       rsp,
  output dsa_stat_s      stat
);

  // modulo wrap: a pointer past either end of the buffer is folded back once
  function automatic dsa_addr_t dsa_modulo(dsa_addr_gen_s a);
    dsa_addr_t len;
    dsa_addr_t ea;
    ea  = a.addr;
    len = `DSA_AW'(a.mod_end - a.mod_start + `DSA_ADDR_ONE);
    if (a.addr > a.mod_end) begin
      ea = `DSA_AW'(a.addr - len);
    end else if (a.addr < a.mod_start) begin
      ea = `DSA_AW'(a.addr + len);
    end
    return ea;
  endfunction

  // reversal of the low br_bits bits; a width past the pointer is clamped,
  // so no bit outside the address is ever read
  function automatic dsa_addr_t dsa_bitrev(dsa_addr_gen_s a);
    dsa_addr_t ea;
    int        n;
    ea = a.addr;
    n  = int'(a.br_bits);
    if (n > `DSA_AW) begin
      n = `DSA_AW;
    end
    for (int k = 0; k < `DSA_AW; k++) begin
      if (k < n) begin
        ea[k] = a.addr[n-1-k];
      end
    end
    return ea;
  endfunction

  // address generator; allow_br says whether bit reversal is legal here
  function automatic dsa_addr_t dsa_agen(dsa_addr_gen_s a, logic allow_br);
    dsa_addr_t ea;
    ea = a.addr;
    if (DSP_ENGINE) begin
      if (a.mode == DSA_MODE_MODULO) begin
        ea = dsa_modulo(a);
      end else if (a.mode == DSA_MODE_BITREV && allow_br) begin
        ea = dsa_bitrev(a);
      end
    end
    return ea;
  endfunction

  // bit reversal asked where it has no meaning is reported
  function automatic logic dsa_br_misuse(dsa_addr_gen_s a, logic allow_br);
    return (a.mode == DSA_MODE_BITREV) && !(allow_br && DSP_ENGINE);
  endfunction

  // mac class: the only operations that open the y read path
  function automatic logic dsa_is_mac(dsa_op_e op);
    logic m;
    case (op)
      DSA_OP_accumulator_clear_op,
      DSA_OP_euclidean_distance_op,
      DSA_OP_euclidean_distance_accumulate_op,
      DSA_OP_MAC,
      DSA_OP_prefetch_store_accumulator_op,
      DSA_OP_multiply_op,
      DSA_OP_multiply_negate_op,
      DSA_OP_multiply_subtract_op: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // fixed boundary, compared against constants only
  function automatic logic dsa_in_y(dsa_addr_t a);
    return a >= `DSA_Y_BASE;
  endfunction

  // storage: one flip-flop bank per space
  dsa_data_t x_mem_reg  [`DSA_X_WORDS];
  dsa_data_t x_mem_next [`DSA_X_WORDS];
  dsa_data_t y_mem_reg  [`DSA_Y_WORDS];
  dsa_data_t y_mem_next [`DSA_Y_WORDS];

  dsa_rsp_s  rsp_reg;
  dsa_rsp_s  rsp_next;
  dsa_stat_s stat_reg;
  dsa_stat_s stat_next;

  // effective addresses from the two generators and the write path
  dsa_addr_t          x_ea;
  dsa_addr_t          y_ea;
  dsa_addr_t          w_ea;
  logic               mac_op;
  logic               w_in_y;
  logic               w_br_ok;
  logic [`DSA_BW-1:0] w_x_idx;
  logic [`DSA_BW-1:0] w_y_idx;
  logic               w_x_en;
  logic               w_y_en;

  // read path decode, worked out once for the answer logic
  logic               x_in_y;
  logic               y_in_y;
  logic [`DSA_BW-1:0] x_x_idx;
  logic [`DSA_BW-1:0] x_y_idx;
  logic [`DSA_BW-1:0] y_y_idx;

  // individual reasons for a dropped addressing mode
  logic               w_br_drop;
  logic               x_br_drop;
  logic               y_br_drop;
  logic               w_mod_drop;
  logic               x_mod_drop;

  // write decode: a bit-reversed pointer is only honoured if its plain
  // target already lies in x, so a pointer whose plain target lies in y is never reversed
  always_comb begin
    mac_op  = dsa_is_mac(rd_req.op);
    w_br_ok = !dsa_in_y(wr_req.gen.addr);
    w_ea    = dsa_agen(wr_req.gen, w_br_ok);
    w_in_y  = dsa_in_y(w_ea);
    w_x_idx = w_ea[`DSA_BW-1:0];
    w_y_idx = `DSA_BW'(w_ea - `DSA_Y_BASE);
    w_x_en  = wr_req.en && !w_in_y;
    w_y_en  = wr_req.en && w_in_y;
  end

  // read address generation: x path never reverses, nor does y
  always_comb begin
    x_ea = dsa_agen(rd_req.x, 1'b0);
    y_ea = dsa_agen(rd_req.y, 1'b0);
    x_in_y  = dsa_in_y(x_ea);
    y_in_y  = dsa_in_y(y_ea);
    x_x_idx = x_ea[`DSA_BW-1:0];
    x_y_idx = `DSA_BW'(x_ea - `DSA_Y_BASE);
    y_y_idx = `DSA_BW'(y_ea - `DSA_Y_BASE);
  end

  // a mode is dropped where it has no meaning or the engine is absent;
  // a y read asking modulo on the lite variant is not reported
  always_comb begin
    w_br_drop  = wr_req.en && dsa_br_misuse(wr_req.gen, w_br_ok);
    x_br_drop  = rd_valid && dsa_br_misuse(rd_req.x, 1'b0);
    y_br_drop  = rd_valid && mac_op && dsa_br_misuse(rd_req.y, 1'b0);
    w_mod_drop = !DSP_ENGINE && wr_req.en && wr_req.gen.mode == DSA_MODE_MODULO;
    x_mod_drop = !DSP_ENGINE && rd_valid && rd_req.x.mode == DSA_MODE_MODULO;
  end

  // per-entry next value of the x bank
  generate
    for (genvar i = 0; i < `DSA_X_WORDS; i++) begin : g_x_mem
      always_comb begin
        x_mem_next[i] = x_mem_reg[i];
        if (w_x_en && w_x_idx == `DSA_BW'(i)) begin
          x_mem_next[i] = wr_req.data;
        end
      end
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          x_mem_reg[i] <= `DSA_DATA_RST;
        end else begin
          x_mem_reg[i] <= x_mem_next[i];
        end
      end
    end
  endgenerate

  // per-entry next value of the y bank
  generate
    for (genvar j = 0; j < `DSA_Y_WORDS; j++) begin : g_y_mem
      always_comb begin
        y_mem_next[j] = y_mem_reg[j];
        if (w_y_en && w_y_idx == `DSA_BW'(j)) begin
          y_mem_next[j] = wr_req.data;
        end
      end
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          y_mem_reg[j] <= `DSA_DATA_RST;
        end else begin
          y_mem_reg[j] <= y_mem_next[j];
        end
      end
    end
  endgenerate

  // read answer; reads see the contents before a same-cycle write,
  // which keeps the read ports free of the write decode timing
  always_comb begin
    rsp_next = '0;
    if (rd_valid && mac_op) begin
      // separate spaces: x word from x, y word from y, same cycle
      rsp_next.x_valid = 1'b1;
      rsp_next.y_valid = 1'b1;
      if (!x_in_y) begin
        rsp_next.x_data = x_mem_reg[x_x_idx];
      end else begin
        rsp_next.range_err = 1'b1;
      end
      if (y_in_y) begin
        rsp_next.y_data = y_mem_reg[y_y_idx];
      end else begin
        rsp_next.range_err = 1'b1;
      end
    end else if (rd_valid && rd_req.op == DSA_OP_READ) begin
      // combined range, always returned on the x read bus
      rsp_next.x_valid = 1'b1;
      if (x_in_y) begin
        rsp_next.x_data = y_mem_reg[x_y_idx];
      end else begin
        rsp_next.x_data = x_mem_reg[x_x_idx];
      end
    end
  end

  // status: where the last write landed and whether a mode was dropped
  always_comb begin
    stat_next              = '0;
    stat_next.wr_done      = wr_req.en;
    stat_next.wr_to_y      = w_y_en;
    stat_next.wr_addr      = wr_req.en ? w_ea : '0;
    stat_next.mode_ignored =
      w_br_drop || x_br_drop || y_br_drop || w_mod_drop || x_mod_drop;
  end

  // answer register; every answer field is a one-cycle pulse
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  // status register, one cycle per write or read
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign rsp  = rsp_reg;
  assign stat = stat_reg;

endmodule

/* dsa_data_space_props.sv */
// assertion checker for the dual data space block
`timescale 1ns/1ps
`include "dsa_consts.svh"
module dsa_data_space_props
  import dsa_pkg::*;
#(
  parameter bit DSP_ENGINE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rd_valid,
  input dsa_rd_s   rd_req,
  input dsa_wr_s   wr_req,
  input dsa_rsp_s  rsp,
  input dsa_stat_s stat
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // request classes at the taking edge
  wire logic mac = rd_valid && rd_req.op[3];
  wire logic rd  = mac || (rd_valid && rd_req.op == DSA_OP_READ);
  wire logic wy  = wr_req.en && wr_req.gen.addr >= `DSA_Y_BASE;
  property p_xv; rd |=> rsp.x_valid; endproperty
  a_xv: assert property (p_xv) else $error("x answer missing");
  property p_idle; !rd |=> !rsp.x_valid; endproperty
  a_idle: assert property (p_idle) else $error("x answer without request");
  property p_yv; rd |=> rsp.y_valid == $past(mac); endproperty
  a_yv: assert property (p_yv) else $error("y path use wrong");
  property p_wd; wr_req.en |=> stat.wr_done; endproperty
  a_wd: assert property (p_wd) else $error("write not done");
  property p_toy; stat.wr_done |-> stat.wr_to_y == (stat.wr_addr >= `DSA_Y_BASE); endproperty
  a_toy: assert property (p_toy) else $error("space decode wrong");
  property p_pl;
    wr_req.en && wr_req.gen.mode == DSA_MODE_PLAIN |=> stat.wr_addr == $past(wr_req.gen.addr);
  endproperty
  a_pl: assert property (p_pl) else $error("plain write address wrong");
  property p_by;
    wy && wr_req.gen.mode == DSA_MODE_BITREV |=> stat.mode_ignored && stat.wr_to_y;
  endproperty
  a_by: assert property (p_by) else $error("y write reversed");
  property p_er;
    mac && rd_req.x.mode == DSA_MODE_PLAIN && rd_req.x.addr >= `DSA_Y_BASE |=>
      rsp.range_err && rsp.x_data == 0;
  endproperty
  a_er: assert property (p_er) else $error("range error missing");
  property p_nd; !DSP_ENGINE && wr_req.en |=> stat.wr_addr == $past(wr_req.gen.addr); endproperty
  a_nd: assert property (p_nd) else $error("lite variant moved address");
  c_mac: cover property (mac ##1 rsp.y_valid);
  c_by: cover property (wy && wr_req.gen.mode == DSA_MODE_BITREV);
  c_er: cover property (rsp.range_err);
endmodule
bind dsa_data_space dsa_data_space_props #(.DSP_ENGINE(DSP_ENGINE)) dsa_data_space_props_inst (
  .ref_clk(ref_clk), .reset(reset), .rd_valid(rd_valid), .rd_req(rd_req),
  .wr_req(wr_req), .rsp(rsp), .stat(stat));

/* dsa_data_space_tb.sv */
// self-checking bench for the dual data space block
`timescale 1ns/1ps
`include "dsa_consts.svh"
module dsa_data_space_tb
  import dsa_pkg::*;
;
  typedef struct {
    logic v; dsa_rd_s rd; dsa_wr_s wr; dsa_data_t ex, ey; logic yv, er, mi; dsa_addr_t wa;
  } dsa_row_s;
  localparam dsa_mode_e pl = DSA_MODE_PLAIN;
  localparam dsa_mode_e md = DSA_MODE_MODULO;
  localparam dsa_mode_e br = DSA_MODE_BITREV;
  localparam dsa_addr_gen_s z = '0;
  logic      ref_clk = 1'b0;
  logic      reset = 1'b1;
  logic      rd_valid;
  dsa_rd_s   rd_req;
  dsa_wr_s   wr_req;
  dsa_rsp_s  rsp;
  dsa_stat_s stat, stat_l;
  int        err_count = 0;
  int        checks = 0;
  dsa_row_s  q[$];
  always #4 ref_clk = ~ref_clk;
  dsa_core_model dsa_core_model_inst (.ref_clk(ref_clk), .rd_valid(rd_valid),
    .rd_req(rd_req), .wr_req(wr_req));
  dsa_data_space dsa_data_space_inst (.ref_clk(ref_clk), .reset(reset), .rd_valid(rd_valid),
    .rd_req(rd_req), .wr_req(wr_req), .rsp(rsp), .stat(stat));
  // variant without the dsp engine shares the stimulus
  dsa_data_space #(.DSP_ENGINE(1'b0)) dsa_data_space_lite_inst (.ref_clk(ref_clk),
    .reset(reset), .rd_valid(rd_valid), .rd_req(rd_req), .wr_req(wr_req), .rsp(),
    .stat(stat_l));
  function automatic dsa_addr_gen_s ag(dsa_mode_e m, dsa_addr_t a, dsa_addr_t s = 8'h00,
                                       dsa_addr_t e = 8'h00, logic [3:0] b = 4'h0);
    return '{m, a, s, e, b};
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic add(dsa_op_e op, dsa_addr_gen_s x, dsa_addr_gen_s y, logic we, dsa_addr_gen_s w,
                     dsa_data_t d, dsa_data_t ex, dsa_data_t ey, logic yv, er, mi, dsa_addr_t wa);
    q.push_back('{op != DSA_OP_NONE, '{op, x, y}, '{we, w, d}, ex, ey, yv, er, mi, wa});
  endtask
  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under 100 cycles
  initial begin
    #2000;
    err_count++;
    complete_run();
  end
  // rows go back to back; each answer is checked one cycle after its request
  initial begin
    add(DSA_OP_NONE, z, z, 1, ag(pl, 8'h10), 16'habcd, 0, 0, 0, 0, 0, 8'h10);
    add(DSA_OP_NONE, z, z, 1, ag(pl, 8'h85), 16'h1234, 0, 0, 0, 0, 0, 8'h85);
    add(DSA_OP_NONE, z, z, 1, ag(br, 8'h01, 0, 0, 4), 16'h5555, 0, 0, 0, 0, 0, 8'h08);
    add(DSA_OP_READ, ag(pl, 8'h10), z, 1, ag(br, 8'h81, 0, 0, 4), 16'h7777,
        16'habcd, 0, 0, 0, 1, 8'h81);
    add(DSA_OP_READ, ag(pl, 8'h85), z, 1, ag(md, 8'h25, 8'h10, 8'h1f), 16'h9999,
        16'h1234, 0, 0, 0, 0, 8'h15);
    add(DSA_OP_MAC, ag(pl, 8'h08), ag(md, 8'h95, 8'h80, 8'h8f), 0, z, 0,
        16'h5555, 16'h1234, 1, 0, 0, 0);
    add(DSA_OP_MAC, ag(br, 8'h15, 0, 0, 4), ag(pl, 8'h81), 0, z, 0, 16'h9999, 16'h7777, 1, 0, 1, 0);
    add(DSA_OP_MAC, ag(pl, 8'h85), ag(pl, 8'h10), 0, z, 0, 0, 0, 1, 1, 0, 0);
    add(DSA_OP_READ, ag(md, 8'h05, 8'h10, 8'h1f), z, 0, z, 0, 16'h9999, 0, 0, 0, 0, 0);
    add(DSA_OP_NONE, z, z, 0, z, 0, 0, 0, 0, 0, 0, 0);
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (q[i]) begin
      dsa_core_model_inst.drive(q[i].v, q[i].rd, q[i].wr);
      #1;
      if (i > 0) begin
        chk("x_valid", 16'(rsp.x_valid), 16'(q[i-1].v));
        chk("wr_done", 16'(stat.wr_done), 16'(q[i-1].wr.en));
        chk("mode_ignored", 16'(stat.mode_ignored), 16'(q[i-1].mi));
      end
      if (i > 0 && q[i-1].v) begin
        chk("x_data", rsp.x_data, q[i-1].ex);
        chk("y_valid", 16'(rsp.y_valid), 16'(q[i-1].yv));
        chk("y_data", rsp.y_data, q[i-1].ey);
        chk("range_err", 16'(rsp.range_err), 16'(q[i-1].er));
      end
      if (i > 0 && q[i-1].wr.en) begin
        chk("wr_addr", 16'(stat.wr_addr), 16'(q[i-1].wa));
        chk("wr_to_y", 16'(stat.wr_to_y), 16'(q[i-1].wa >= `DSA_Y_BASE));
        chk("lite_addr", 16'(stat_l.wr_addr), 16'(q[i-1].wr.gen.addr));
      end
    end
    // every mac-class code opens the y read path
    for (int c = 8; c < 16; c++) begin
      dsa_core_model_inst.drive(1'b1, '{dsa_op_e'(c), ag(pl, 8'h10), ag(pl, 8'h85)}, '0);
      dsa_core_model_inst.drive(1'b0, '0, '0);
      #1;
      chk("mac_y", rsp.y_data, 16'h1234);
      chk("mac_x", rsp.x_data, 16'habcd);
    end
    // an undecoded operation code opens neither read path
    dsa_core_model_inst.drive(1'b1, '{dsa_op_e'(2), ag(pl, 8'h10), ag(pl, 8'h85)}, '0);
    dsa_core_model_inst.drive(1'b0, '0, '0);
    #1;
    chk("undecoded_x", 16'(rsp.x_valid), 16'h0000);
    chk("undecoded_y", 16'(rsp.y_valid), 16'h0000);
    // reset in mid-run clears answers and memory
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("rst_x_valid", 16'(rsp.x_valid), 16'h0000);
    chk("rst_wr_done", 16'(stat.wr_done), 16'h0000);
    @(posedge ref_clk);
    reset <= 1'b0;
    dsa_core_model_inst.drive(1'b1, '{DSA_OP_READ, ag(pl, 8'h10), z}, '0);
    dsa_core_model_inst.drive(1'b0, '0, '0);
    #1;
    chk("rst_mem", rsp.x_data, 16'h0000);
    chk("rst_rd_valid", 16'(rsp.x_valid), 16'h0001);
    complete_run();
  end
endmodule

/* dsa_pkg.sv */
// types shared by the dual data space access block
`include "dsa_consts.svh"

package dsa_pkg;

  // operation classes; the mac class may use the y read path
  typedef enum logic [3:0] {
    DSA_OP_NONE                             = 4'h0,
    DSA_OP_READ                             = 4'h1,
    DSA_OP_accumulator_clear_op             = 4'h8,
    DSA_OP_euclidean_distance_op            = 4'h9,
    DSA_OP_euclidean_distance_accumulate_op = 4'ha,
    DSA_OP_MAC                              = 4'hb,
    DSA_OP_prefetch_store_accumulator_op    = 4'hc,
    DSA_OP_multiply_op                      = 4'hd,
    DSA_OP_multiply_negate_op               = 4'he,
    DSA_OP_multiply_subtract_op             = 4'hf
  } dsa_op_e;

  // address generator modes
  typedef enum logic [1:0] {
    DSA_MODE_PLAIN  = 2'h0,
    DSA_MODE_MODULO = 2'h1,
    DSA_MODE_BITREV = 2'h3
  } dsa_mode_e;

  typedef logic [`DSA_AW-1:0] dsa_addr_t;
  typedef logic [`DSA_DW-1:0] dsa_data_t;

  // one address generator request
  typedef struct packed {
    dsa_mode_e            mode;
    dsa_addr_t            addr;
    dsa_addr_t            mod_start;
    dsa_addr_t            mod_end;
    logic [`DSA_BRW-1:0]  br_bits;
  } dsa_addr_gen_s;

  // read request: x path always, y path for the mac class
  typedef struct packed {
    dsa_op_e       op;
    dsa_addr_gen_s x;
    dsa_addr_gen_s y;
  } dsa_rd_s;

  // write request over the combined range
  typedef struct packed {
    logic          en;
    dsa_addr_gen_s gen;
    dsa_data_t     data;
  } dsa_wr_s;

  // read answer
  typedef struct packed {
    logic      x_valid;
    dsa_data_t x_data;
    logic      y_valid;
    dsa_data_t y_data;
    logic      range_err;
  } dsa_rsp_s;

  // status of the last cycle
  typedef struct packed {
    logic      wr_done;
    logic      wr_to_y;
    dsa_addr_t wr_addr;
    logic      mode_ignored;
  } dsa_stat_s;

endpackage
